// File: hw/mfir_pkg.sv
// Shared constants and types of the management flag and interrupt register bank.
// Assumes a single 125 MHz clock and a synchronous active-high reset.
package mfir_pkg;
  localparam int CLK_PERIOD_NS = 8; // Period of ref_clk
  localparam int DATA_W = 8; // Byte width of the window
  localparam int ADDR_W = 8; // 256-byte host window
  localparam int LOW_W = 7; // Offset width inside a 128-byte region
  localparam int UPPER_BIT = 7; // Address bit that selects upper memory
  localparam int PAGE_BYTES = 128; // Bytes per region or page
  localparam int NUM_PAGES = 4; // Pages that can be mapped upward
  localparam int PSEL_W = 2; // Page select width
  localparam int NUM_FLAGS = 8; // Flags in the flag byte
  localparam int CNT_W = 16; // Monitor result width
  localparam int TMR_W = 10; // Gating timer width
  // Lower memory locations with hardware behind them
  localparam logic [LOW_W-1:0] ADDR_FLAGS = 7'h03;
  localparam logic [LOW_W-1:0] ADDR_MASKS = 7'h04;
  localparam logic [LOW_W-1:0] ADDR_MON_CTRL = 7'h05;
  localparam logic [LOW_W-1:0] ADDR_RES_LO = 7'h06;
  localparam logic [LOW_W-1:0] ADDR_RES_HI = 7'h07;
  localparam logic [LOW_W-1:0] ADDR_MON_STAT = 7'h08;
  localparam logic [LOW_W-1:0] ADDR_PAGE_SEL = 7'h7F;
  // Monitor control byte fields
  localparam int CTRL_TRIG = 0; // On-demand trigger, self clearing
  localparam int CTRL_START = 1; // Ungated start, self clearing
  localparam int CTRL_STOP = 2; // Ungated stop, self clearing
  localparam int CTRL_FREEZE = 3; // Hold the live result
  localparam int CTRL_MODE_LSB = 4; // Gating mode field
  localparam int CTRL_MODE_MSB = 5;
  // Monitor status byte fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_FLAT = 1;
  // Reset values
  localparam logic [DATA_W-1:0] MASK_RST = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  // Gating and idle times
  localparam int GATE_TIME_NS = 8000;
  localparam int GATE_CYCLES = GATE_TIME_NS / CLK_PERIOD_NS;
  localparam int IDLE_TIME_NS = 400;
  localparam int IDLE_CYCLES = IDLE_TIME_NS / CLK_PERIOD_NS;
  // Gating modes of the monitor
  typedef enum logic [1:0] {MODE_UNGATED, MODE_ON_DEMAND, MODE_PERIODIC, MODE_RSVD} mfir_mode_t;
  // Monitor sequencer states
  typedef enum logic [1:0] {MON_IDLE, MON_GATE, MON_HOLD, MON_RUN} mfir_mon_t;
endpackage : mfir_pkg

// File: hw/mfir_flags.sv
// Flag byte with per-Flag masks and the aggregated interrupt request.
// Assumes clear and write strobes come from access logic on the same clock.
module mfir_flags import mfir_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [NUM_FLAGS-1:0] set_evt,
  input wire logic rd_clr,
  input wire logic mask_wr,
  input wire logic [NUM_FLAGS-1:0] mask_wdata,
  output logic [NUM_FLAGS-1:0] flags,
  output logic [NUM_FLAGS-1:0] masks,
  output logic int_req
);
  ////////////////////////////////////////////////////////////////////////////
  // One latch per bit; an event always beats a read clear
  for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        flags[i] <= 1'b0;
      end else if (set_evt[i]) begin
        flags[i] <= 1'b1;
      end else if (rd_clr) begin
        flags[i] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host written masks beside the flags
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      masks <= MASK_RST;
    end else if (mask_wr) begin
      masks <= mask_wdata;
    end
  end

  // Registered request: any unmasked Flag set
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      int_req <= 1'b0;
    end else begin
      int_req <= |(flags & ~masks);
    end
  end

  a_flag_sticky: assert property (@(posedge ref_clk) disable iff (rst)
    flags[0] && !rd_clr |=> flags[0])
    else $error("flag dropped without a read");
  a_flag_read_clear: assert property (@(posedge ref_clk) disable iff (rst)
    rd_clr && !set_evt[0] |=> !flags[0])
    else $error("flag not cleared by read");
  a_set_beats_clear: assert property (@(posedge ref_clk) disable iff (rst)
    rd_clr |=> flags == $past(set_evt))
    else $error("event lost under read clear");
  a_irq_follows: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 int_req == |($past(flags) & ~$past(masks)))
    else $error("interrupt not tracking flags");
  a_mask_ceases: assert property (@(posedge ref_clk) disable iff (rst)
    mask_wr && (((flags | set_evt) & ~mask_wdata) == '0) |=> ##1 !int_req)
    else $error("masked flags still interrupt");
endmodule : mfir_flags

// File: hw/mfir_monitor.sv
// Event counting monitor with ungated, on-demand and periodic gating.
// Assumes command pulses and measured events are on ref_clk.
module mfir_monitor import mfir_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst,
  input mfir_mode_t mode,
  input wire logic trig,
  input wire logic start,
  input wire logic stop,
  input wire logic freeze,
  input wire logic meas_event,
  output logic [CNT_W-1:0] result,
  output logic busy
);
  localparam logic [TMR_W-1:0] GATE_LAST = TMR_W'(GATE_CYCLES - 1);
  localparam logic [TMR_W-1:0] IDLE_LAST = TMR_W'(IDLE_CYCLES - 1);
  mfir_mon_t state; // Sequencer state
  logic [TMR_W-1:0] timer; // Gate and idle timer
  logic [CNT_W-1:0] live; // Running count
  logic [CNT_W-1:0] next_live; // Count including this cycle
  logic gate_end; // Last cycle of a gating period

  assign next_live = live + CNT_W'(meas_event);
  assign gate_end = (state == MON_GATE) && (timer == GATE_LAST);
  assign busy = (state != MON_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer and timer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= MON_IDLE;
      timer <= '0;
    end else begin
      timer <= timer + 1'b1;
      unique case (state)
        MON_IDLE: begin
          timer <= '0;
          if (mode == MODE_PERIODIC) begin
            state <= MON_GATE;
          end else if (mode == MODE_ON_DEMAND && trig) begin
            state <= MON_GATE;
          end else if (mode == MODE_UNGATED && start) begin
            state <= MON_RUN;
          end
        end
        MON_GATE: begin
          if (gate_end) begin
            timer <= '0;
            // Periodic restarts at once, on-demand rests
            state <= (mode == MODE_PERIODIC) ? MON_GATE : MON_HOLD;
          end
        end
        MON_HOLD: begin
          if (timer == IDLE_LAST) begin
            state <= MON_IDLE;
          end
        end
        MON_RUN: begin
          timer <= '0;
          if (stop || mode != MODE_UNGATED) begin
            state <= MON_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Live count, restarted at each gate start
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      live <= '0;
    end else if (gate_end || (state == MON_IDLE)) begin
      live <= '0;
    end else if (state == MON_GATE || state == MON_RUN) begin
      live <= next_live;
    end
  end

  // Result: sampled at gate end, or live when ungated and not frozen
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      result <= '0;
    end else if (gate_end) begin
      result <= next_live;
    end else if (state == MON_RUN && !freeze) begin
      result <= next_live;
    end
  end

  a_periodic_no_gap: assert property (@(posedge ref_clk) disable iff (rst)
    gate_end && mode == MODE_PERIODIC |=> state == MON_GATE && timer == '0)
    else $error("periodic gate left a gap");
  a_freeze_holds: assert property (@(posedge ref_clk) disable iff (rst)
    state == MON_RUN && freeze && !gate_end |=> $stable(result))
    else $error("frozen result changed");
  a_ungated_stop: assert property (@(posedge ref_clk) disable iff (rst)
    state == MON_RUN && stop |=> state == MON_IDLE)
    else $error("ungated run ignored stop");
endmodule : mfir_monitor

// File: hw/mfir_top.sv
// Management register window: lower memory, paged upper memory, Flags,
// masks, interrupt request and one gated monitor.
// Assumes the link decoder hands over byte accesses on ref_clk.
// The flat strap arrives from a pin and is synchronised.

module mfir_top import mfir_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [ADDR_W-1:0] acc_addr,
  input wire logic [DATA_W-1:0] acc_wdata,
  output logic rd_valid,
  output logic [DATA_W-1:0] rd_data,
  input wire logic [NUM_FLAGS-1:0] flag_event,
  input wire logic meas_event,
  input wire logic flat_strap_pin,
  output logic int_req,
  output logic flat_mode,
  output logic [PSEL_W-1:0] page_sel
);
  localparam int UP_W = PSEL_W + LOW_W; // Upper storage index width

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [DATA_W-1:0] low_mem [PAGE_BYTES]; // Plain lower memory bytes
  logic [DATA_W-1:0] up_mem [NUM_PAGES*PAGE_BYTES]; // All upper pages
  logic strap_meta; // First synchroniser stage
  logic strap_sync; // Second synchroniser stage
  logic strap_taken; // Strap already captured
  logic is_wr; // Write request this cycle
  logic is_rd; // Read request this cycle
  logic is_up; // Address in upper window
  logic [LOW_W-1:0] off; // Offset within region
  logic [PSEL_W-1:0] eff_page; // Page actually mapped
  logic [UP_W-1:0] up_idx; // Index into upper storage
  logic low_special; // Offset has hardware behind it
  logic wr_mask; // Mask byte write
  logic wr_ctrl; // Monitor control write
  logic wr_psel; // Page select write
  logic rd_flags; // Flag byte read
  logic [NUM_FLAGS-1:0] flags; // Flag byte
  logic [NUM_FLAGS-1:0] masks; // Mask byte
  logic mon_trig; // Trigger pulse
  logic mon_start; // Ungated start pulse
  logic mon_stop; // Ungated stop pulse
  logic mon_freeze; // Freeze control
  mfir_mode_t mon_mode; // Gating mode
  logic [CNT_W-1:0] mon_result; // Monitor result
  logic mon_busy; // Monitor active
  logic [DATA_W-1:0] ctrl_rd; // Control byte as read back
  logic [DATA_W-1:0] stat_rd; // Status byte
  logic [DATA_W-1:0] next_rd_data; // Read value this cycle

  ////////////////////////////////////////////////////////////////////////////
  // Access decode
  assign is_wr = acc_valid && acc_write;
  assign is_rd = acc_valid && !acc_write;
  assign is_up = acc_addr[UPPER_BIT];
  assign off = acc_addr[LOW_W-1:0];
  assign eff_page = flat_mode ? '0 : page_sel;
  assign up_idx = {eff_page, off};
  assign low_special = (off == ADDR_FLAGS) || (off == ADDR_MASKS) ||
                       (off == ADDR_MON_CTRL) || (off == ADDR_RES_LO) ||
                       (off == ADDR_RES_HI) || (off == ADDR_MON_STAT) ||
                       (off == ADDR_PAGE_SEL);
  assign wr_mask = is_wr && !is_up && (off == ADDR_MASKS);
  assign wr_ctrl = is_wr && !is_up && (off == ADDR_MON_CTRL);
  assign wr_psel = is_wr && !is_up && (off == ADDR_PAGE_SEL);
  assign rd_flags = is_rd && !is_up && (off == ADDR_FLAGS);

  ////////////////////////////////////////////////////////////////////////////
  // Flat strap: two-stage synchroniser, free running through reset so that
  // the strap level is already settled when reset releases
  always_ff @(posedge ref_clk) begin
    strap_meta <= flat_strap_pin;
    strap_sync <= strap_meta;
  end

  // Capture the strap once after reset release, then hold it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      strap_taken <= 1'b0;
      flat_mode <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      flat_mode <= strap_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page select: ignored and zero on a flat module
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      page_sel <= '0;
    end else if (flat_mode) begin
      page_sel <= '0;
    end else if (wr_psel) begin
      page_sel <= acc_wdata[PSEL_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Plain lower memory bytes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        low_mem[i] <= BYTE_ZERO;
      end
    end else if (is_wr && !is_up && !low_special) begin
      low_mem[off] <= acc_wdata;
    end
  end

  // Upper window storage, one page seen at a time
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_PAGES * PAGE_BYTES; i++) begin
        up_mem[i] <= BYTE_ZERO;
      end
    end else if (is_wr && is_up) begin
      up_mem[up_idx] <= acc_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Monitor control: mode and freeze stored, command bits pulse once
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mon_mode <= MODE_UNGATED;
      mon_freeze <= 1'b0;
    end else if (wr_ctrl) begin
      mon_mode <= mfir_mode_t'(acc_wdata[CTRL_MODE_MSB:CTRL_MODE_LSB]);
      mon_freeze <= acc_wdata[CTRL_FREEZE];
    end
  end

  // Command pulses, one cycle after the control write
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mon_trig <= 1'b0;
      mon_start <= 1'b0;
      mon_stop <= 1'b0;
    end else begin
      mon_trig <= wr_ctrl && acc_wdata[CTRL_TRIG];
      mon_start <= wr_ctrl && acc_wdata[CTRL_START];
      mon_stop <= wr_ctrl && acc_wdata[CTRL_STOP];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags, masks and interrupt
  mfir_flags u_flags (
    .ref_clk(ref_clk),
    .rst(rst),
    .set_evt(flag_event),
    .rd_clr(rd_flags),
    .mask_wr(wr_mask),
    .mask_wdata(acc_wdata[NUM_FLAGS-1:0]),
    .flags(flags),
    .masks(masks),
    .int_req(int_req)
  );

  // Gated monitor
  mfir_monitor u_monitor (
    .ref_clk(ref_clk),
    .rst(rst),
    .mode(mon_mode),
    .trig(mon_trig),
    .start(mon_start),
    .stop(mon_stop),
    .freeze(mon_freeze),
    .meas_event(meas_event),
    .result(mon_result),
    .busy(mon_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read back values
  always_comb begin
    ctrl_rd = BYTE_ZERO;
    ctrl_rd[CTRL_FREEZE] = mon_freeze;
    ctrl_rd[CTRL_MODE_MSB:CTRL_MODE_LSB] = mon_mode;
    stat_rd = BYTE_ZERO;
    stat_rd[STAT_BUSY] = mon_busy;
    stat_rd[STAT_FLAT] = flat_mode;
  end

  // Read multiplexer
  always_comb begin
    next_rd_data = BYTE_ZERO;
    if (is_up) begin
      next_rd_data = up_mem[up_idx];
    end else begin
      unique case (off)
        ADDR_FLAGS: next_rd_data = flags;
        ADDR_MASKS: next_rd_data = masks;
        ADDR_MON_CTRL: next_rd_data = ctrl_rd;
        ADDR_RES_LO: next_rd_data = mon_result[DATA_W-1:0];
        ADDR_RES_HI: next_rd_data = mon_result[CNT_W-1:DATA_W];
        ADDR_MON_STAT: next_rd_data = stat_rd;
        ADDR_PAGE_SEL: next_rd_data = DATA_W'(page_sel);
        default: next_rd_data = low_mem[off];
      endcase
    end
  end

  // Registered read answer, one cycle after the request
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_data <= BYTE_ZERO;
    end else begin
      rd_valid <= is_rd;
      if (is_rd) begin
        rd_data <= next_rd_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_read_answer: assert property (@(posedge ref_clk) disable iff (rst)
    is_rd |=> rd_valid)
    else $error("read not answered next cycle");
  a_flat_page_zero: assert property (@(posedge ref_clk) disable iff (rst)
    flat_mode |=> page_sel == '0)
    else $error("flat module paged");
  a_mask_write: assert property (@(posedge ref_clk) disable iff (rst)
    wr_mask |=> masks == $past(acc_wdata))
    else $error("mask write lost");
  a_flag_read_value: assert property (@(posedge ref_clk) disable iff (rst)
    rd_flags |=> rd_data == $past(flags))
    else $error("flag byte read wrong");
  a_trig_starts_gate: assert property (@(posedge ref_clk) disable iff (rst)
    wr_ctrl && acc_wdata[CTRL_TRIG] && !mon_busy && !acc_wdata[CTRL_MODE_MSB] &&
    acc_wdata[CTRL_MODE_LSB] |-> ##2 mon_busy)
    else $error("trigger did not start gate");
endmodule : mfir_top

// File: verification/mfir_host_model.sv
// Host side of the management link: issues byte writes and reads.
// Assumes the design takes a request on the rising edge of ref_clk
// and answers a read exactly one cycle later.
module mfir_host_model import mfir_pkg::*; (
  input wire logic ref_clk,
  output logic acc_valid,
  output logic acc_write,
  output logic [ADDR_W-1:0] acc_addr,
  output logic [DATA_W-1:0] acc_wdata,
  input wire logic rd_valid,
  input wire logic [DATA_W-1:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////
  // Quiet bus at time zero
  initial begin
    acc_valid = 1'b0;
    acc_write = 1'b0;
    acc_addr = 8'h00;
    acc_wdata = 8'h00;
  end

  // Released qualifiers show the inverse of their last value,
  // so a design that samples them outside a request sees junk
  task automatic release_bus();
    acc_valid = 1'b0;
    acc_write = ~acc_write;
    acc_addr = ~acc_addr;
    acc_wdata = ~acc_wdata;
  endtask : release_bus

  ////////////////////////////////////////////////////////////////////
  // One write; trigger, start and stop commands travel this way too
  task automatic host_write(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
    @(negedge ref_clk);
    acc_valid = 1'b1;
    acc_write = 1'b1;
    acc_addr = addr;
    acc_wdata = data;
    @(posedge ref_clk);
    @(negedge ref_clk);
    release_bus();
  endtask : host_write

  // One read; answer sampled in the cycle after the taking edge
  task automatic host_read(input logic [ADDR_W-1:0] addr, output logic vld,
                           output logic [DATA_W-1:0] data);
    @(negedge ref_clk);
    acc_valid = 1'b1;
    acc_write = 1'b0;
    acc_addr = addr;
    @(posedge ref_clk);
    @(negedge ref_clk);
    vld = rd_valid;
    data = rd_data;
    release_bus();
  endtask : host_read
endmodule : mfir_host_model

// File: verification/mgmt_flag_interrupt_regs_tb_top.sv
// Self-checking bench of the management register window.
// Assumes the host model drives the link; flag, event and strap
// inputs are driven here on the falling edge of ref_clk.
`define MFIR_CHK(got, exp, msg) begin check_count++; if ((got) !== (exp)) begin \
  num_errors++; $display("CHECK FAILED at %0t: %s", $time, msg); end end

module mgmt_flag_interrupt_regs_tb_top import mfir_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk = 1'b0; // Bench clock
  logic rst = 1'b1; // Synchronous reset
  logic acc_valid, acc_write, rd_valid, int_req, flat_mode;
  logic [ADDR_W-1:0] acc_addr;
  logic [DATA_W-1:0] acc_wdata, rd_data;
  logic [PSEL_W-1:0] page_sel;
  logic [NUM_FLAGS-1:0] flag_event = 8'h00; // Flag set events
  logic meas_event = 1'b0; // Monitored events
  logic flat_strap_pin = 1'b0; // Paged module by default
  logic [DATA_W-1:0] d; // Last read byte
  logic [DATA_W-1:0] base; // Live count before an ungated run
  int num_errors = 0;
  int check_count = 0;
  // Full host addresses of the lower memory registers
  localparam logic [ADDR_W-1:0] A_FLG = {1'b0, ADDR_FLAGS};
  localparam logic [ADDR_W-1:0] A_MSK = {1'b0, ADDR_MASKS};
  localparam logic [ADDR_W-1:0] A_CTL = {1'b0, ADDR_MON_CTRL};
  localparam logic [ADDR_W-1:0] A_RLO = {1'b0, ADDR_RES_LO};
  localparam logic [ADDR_W-1:0] A_STS = {1'b0, ADDR_MON_STAT};
  localparam logic [ADDR_W-1:0] A_PSL = {1'b0, ADDR_PAGE_SEL};

  // Clock of 8 ns period
  always #4 ref_clk = ~ref_clk;

  mfir_top u_dut (.ref_clk(ref_clk), .rst(rst), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .rd_valid(rd_valid), .rd_data(rd_data), .flag_event(flag_event),
    .meas_event(meas_event), .flat_strap_pin(flat_strap_pin), .int_req(int_req),
    .flat_mode(flat_mode), .page_sel(page_sel));

  mfir_host_model u_host (.ref_clk(ref_clk), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .rd_valid(rd_valid), .rd_data(rd_data));

  ////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc

  task automatic do_reset();
    @(negedge ref_clk);
    rst = 1'b1;
    cyc(20);
    rst = 1'b0;
  endtask : do_reset

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    u_host.host_write(a, v);
  endtask : wr

  // Read into d; the answer must come one cycle after the request
  task automatic rd(input logic [ADDR_W-1:0] a);
    logic v;
    u_host.host_read(a, v, d);
    `MFIR_CHK(v, 1'b1, "no read answer")
  endtask : rd

  // Single-cycle flag pulse
  task automatic pulse_flag(input logic [NUM_FLAGS-1:0] v);
    flag_event = v;
    cyc(1);
    flag_event = 8'h00;
  endtask : pulse_flag

  // Spaced monitored events, one every second cycle
  task automatic events(input int n);
    repeat (n) begin
      meas_event = 1'b1;
      cyc(1);
      meas_event = 1'b0;
      cyc(1);
    end
  endtask : events

  ////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic test_reset();
    cyc(2);
    `MFIR_CHK(int_req, 1'b0, "int_req after reset")
    `MFIR_CHK(page_sel, 2'h0, "page_sel after reset")
    rd(A_MSK);
    `MFIR_CHK(d, MASK_RST, "mask reset value")
  endtask : test_reset

  // Flag stays after event, read clears it and the interrupt
  task automatic test_flags();
    pulse_flag(8'h01);
    cyc(2);
    `MFIR_CHK(int_req, 1'b1, "int_req not raised")
    cyc(10);
    `MFIR_CHK(int_req, 1'b1, "int_req dropped early")
    rd(A_FLG);
    `MFIR_CHK(d, 8'h01, "flag lost")
    cyc(1);
    `MFIR_CHK(int_req, 1'b0, "int_req after clear")
    rd(A_FLG);
    `MFIR_CHK(d, 8'h00, "flag not cleared")
  endtask : test_flags

  // Mask suppresses and ends the interrupt of its own Flag only
  task automatic test_mask();
    pulse_flag(8'h06);
    cyc(2);
    wr(A_MSK, 8'h04);
    cyc(2);
    `MFIR_CHK(int_req, 1'b1, "other flag masked")
    wr(A_MSK, 8'h06);
    cyc(2);
    `MFIR_CHK(int_req, 1'b0, "mask did not end int")
    rd(A_MSK);
    `MFIR_CHK(d, 8'h06, "mask readback")
    wr(A_MSK, 8'h00);
    cyc(2);
    `MFIR_CHK(int_req, 1'b1, "unmask did not raise")
    rd(A_FLG);
    `MFIR_CHK(d, 8'h06, "masked flags lost")
  endtask : test_mask

  // Event during the clearing read keeps the flag
  task automatic test_race();
    flag_event = 8'h80;
    rd(A_FLG);
    flag_event = 8'h00;
    `MFIR_CHK(d, 8'h80, "flag under event")
    rd(A_FLG);
    `MFIR_CHK(d, 8'h80, "event lost in clear")
    rd(A_FLG);
    `MFIR_CHK(d, 8'h00, "flag not cleared")
  endtask : test_race

  // Lower memory unpaged, upper window follows page select
  task automatic test_pages();
    wr(8'h10, 8'hA5);
    wr(8'h80, 8'h5A);
    wr(8'hFF, 8'hC3);
    wr(A_PSL, 8'h01);
    cyc(1);
    `MFIR_CHK(page_sel, 2'h1, "page select")
    rd(8'h80);
    `MFIR_CHK(d, 8'h00, "page 1 not mapped")
    wr(8'h80, 8'h3C);
    rd(8'h10);
    `MFIR_CHK(d, 8'hA5, "lower memory paged")
    wr(A_PSL, 8'h00);
    rd(8'h80);
    `MFIR_CHK(d, 8'h5A, "page 0 lost")
    rd(8'hFF);
    `MFIR_CHK(d, 8'hC3, "top byte")
  endtask : test_pages

  // Trigger starts one timed gate; later events are not counted
  task automatic test_on_demand();
    wr(A_CTL, 8'h11);
    rd(A_STS);
    `MFIR_CHK(d[STAT_BUSY], 1'b1, "gate not started")
    events(100);
    cyc(900);
    rd(A_STS);
    `MFIR_CHK(d[STAT_BUSY], 1'b0, "gate not ended")
    events(10);
    rd(A_RLO);
    `MFIR_CHK(d, 8'h64, "on-demand count")
  endtask : test_on_demand

  // Back-to-back periods each see every event
  task automatic test_periodic();
    wr(A_CTL, 8'h20);
    meas_event = 1'b1;
    cyc(2500);
    rd(A_RLO);
    `MFIR_CHK(d, 8'hE8, "period count low")
    rd(A_RLO + 8'h01);
    `MFIR_CHK(d, 8'h03, "period count high")
    meas_event = 1'b0;
    cyc(2100);
    rd(A_RLO);
    `MFIR_CHK(d, 8'h00, "period not resampled")
  endtask : test_periodic

  // Ungated run between start and stop, with freeze; the periodic gate
  // still open must finish its period and rest before start is taken
  task automatic test_ungated();
    wr(A_CTL, 8'h00);
    cyc(1100);
    rd(A_STS);
    `MFIR_CHK(d[STAT_BUSY], 1'b0, "monitor not idle")
    wr(A_CTL, 8'h02);
    cyc(3);
    rd(A_RLO);
    base = d;
    events(20);
    cyc(3);
    wr(A_CTL, 8'h08);
    cyc(3);
    events(20);
    rd(A_RLO);
    `MFIR_CHK(d, base + 8'h14, "freeze not held")
    wr(A_CTL, 8'h00);
    cyc(3);
    rd(A_RLO);
    `MFIR_CHK(d, base + 8'h28, "live count")
    cyc(1200);
    rd(A_STS);
    `MFIR_CHK(d[STAT_BUSY], 1'b1, "ungated run timed out")
    wr(A_CTL, 8'h04);
    cyc(3);
    events(20);
    rd(A_RLO);
    `MFIR_CHK(d, base + 8'h28, "counted after stop")
    rd(A_STS);
    `MFIR_CHK(d[STAT_BUSY], 1'b0, "stop ignored")
  endtask : test_ungated

  // Flat module: whole window direct, page select ignored
  task automatic test_flat();
    flat_strap_pin = 1'b1;
    do_reset();
    cyc(2);
    `MFIR_CHK(flat_mode, 1'b1, "strap not taken")
    wr(A_PSL, 8'h01);
    cyc(1);
    `MFIR_CHK(page_sel, 2'h0, "flat module paged")
    rd(A_STS);
    `MFIR_CHK(d[STAT_FLAT], 1'b1, "flat status")
    wr(8'h90, 8'h77);
    rd(8'h90);
    `MFIR_CHK(d, 8'h77, "flat upper byte")
  endtask : test_flat

  ////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic finish_test();
    if (num_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  // Main sequence
  initial begin
    do_reset();
    test_reset();
    test_flags();
    test_mask();
    test_race();
    test_pages();
    test_on_demand();
    test_periodic();
    test_ungated();
    test_flat();
    finish_test();
  end

  // Watchdog well beyond the expected 8300 cycles
  initial begin
    repeat (30000) @(posedge ref_clk);
    num_errors++;
    finish_test();
  end
endmodule : mgmt_flag_interrupt_regs_tb_top
